// ### hw/gpio_port_block.sv
// general purpose pin block: mode control, pad drive, input sampling, pin interrupts and wake-up
// Operation
// - pins grouped in six ports: five of 16, one of 4; 84 pins total.
// - mode 00: pin is input only, output driver off.
// - level input register shows the current state of every pin.
// - mode 01: push-pull drive of the output data bit.
// - mode 10: drive low for data 0, release for data 1.
// - mode 11: quasi-bidirectional, drive low whenever data bit is 0.
// - quasi with data 1: if pin low, drive strong high two cycles, then release.
// - internal pull-up on only in quasi-bidirectional mode.
// - after reset every pin mode comes from the boot configuration bit.
// - per-pin choice of TTL or Schmitt input buffer, one bit per pin.
// - enabled pin interrupts trigger on low, high, falling or rising.
// - optional debounce for edge triggers, shared clock source and cycle count.
// - interrupt enable also enables the pin as a wake-up source.
// - wake-up in idle or power-down uses the interrupt trigger condition.
`timescale 1ns/1ps
module gpio_port_block
  import gpio_port_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_boot_config_word_quasi,
  input wire logic i_mode_write,
  input wire logic [2*N-1:0] i_pin_mode_select,
  input wire logic [N-1:0] i_pin_output_value,
  input wire logic [N-1:0] i_input_buffer_type,
  input wire logic [N-1:0] i_pin_irq_enable,
  input wire logic [2*N-1:0] i_pin_irq_trigger_type,
  input wire logic [N-1:0] i_debounce_enable,
  input wire debounce_cfg_s i_debounce_cfg,
  input wire logic i_debounce_tick,
  input wire logic [N-1:0] i_irq_status_clear,
  input wire logic i_low_power,
  input wire logic [N-1:0] i_pin,
  output logic [N-1:0] o_pin_out,
  output logic [N-1:0] o_pin_oe,
  output logic [N-1:0] o_pull_up_en,
  output logic [N-1:0] o_schmitt_sel,
  output logic [2*N-1:0] o_pin_mode,
  output logic [N-1:0] o_pin_level_input,
  output logic [N-1:0] o_irq_status,
  output logic o_irq,
  output logic o_wakeup
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [N-1:0] mode_mask(input logic [2*N-1:0] m, input logic [1:0] code);
    logic [N-1:0] r;
    r = '0;
    for (int i = 0; i < N; i++) begin
      r[i] = (m[2*i +: 2] == code);
    end
    return r;
  endfunction

  // ****************************************
  // mode register and boot load
  // ****************************************
  logic boot_done;
  logic next_boot_done;
  logic [2*N-1:0] mode;
  logic [2*N-1:0] next_mode;

  always_comb begin
    next_boot_done = boot_done;
    next_mode = mode;
    if (!boot_done) begin
      // strap is sampled by a clocked load after release, never under reset
      next_mode = {N{i_boot_config_word_quasi ? MODE_QUASI : MODE_INPUT}};
      next_boot_done = 1'b1;
    end else if (i_mode_write) begin
      next_mode = i_pin_mode_select;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boot_done <= RESET_LOW;
      mode <= '0;
    end else if (i_clk_en) begin
      boot_done <= next_boot_done;
      mode <= next_mode;
    end
  end

  // ****************************************
  // input synchroniser and debounce
  // ****************************************
  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] filt;
  logic [N-1:0] next_filt;
  logic [DEBOUNCE_COUNT_WIDTH-1:0] db_cnt [N];
  logic [DEBOUNCE_COUNT_WIDTH-1:0] next_db_cnt [N];
  logic db_tick;
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic armed;

  assign db_tick = i_debounce_cfg.use_tick ? i_debounce_tick : 1'b1;
  // sync and filter flops reset low while idle pins sit high: hold off decisions until they carry real levels
  assign armed = (settle == INPUT_SETTLE_CYCLES);

  always_comb begin
    next_settle = settle;
    if (!armed) begin
      next_settle = settle + 3'h1;
    end
  end

  always_comb begin
    next_filt = filt;
    for (int i = 0; i < N; i++) begin
      next_db_cnt[i] = db_cnt[i];
      if (!armed) begin
        next_filt[i] = sync_b[i];
        next_db_cnt[i] = '0;
      end else if (sync_b[i] == filt[i]) begin
        next_db_cnt[i] = '0;
      end else if (db_tick) begin
        if (db_cnt[i] >= i_debounce_cfg.cycles) begin
          next_filt[i] = sync_b[i];
          next_db_cnt[i] = '0;
        end else begin
          next_db_cnt[i] = db_cnt[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
      filt <= '0;
      settle <= '0;
      for (int i = 0; i < N; i++) begin
        db_cnt[i] <= '0;
      end
    end else if (i_clk_en) begin
      sync_a <= i_pin;
      sync_b <= sync_a;
      filt <= next_filt;
      settle <= next_settle;
      for (int i = 0; i < N; i++) begin
        db_cnt[i] <= next_db_cnt[i];
      end
    end
  end

  // ****************************************
  // quasi-bidirectional strong-high kick
  // ****************************************
  logic [N-1:0] quasi;
  logic [N-1:0] kick_seen;
  logic [N-1:0] next_kick_seen;
  logic [1:0] kick_cnt [N];
  logic [1:0] next_kick_cnt [N];

  assign quasi = mode_mask(mode, MODE_QUASI);

  // one kick per rise of the data bit, so an externally held low pin is not fought forever
  always_comb begin
    next_kick_seen = kick_seen;
    for (int i = 0; i < N; i++) begin
      next_kick_cnt[i] = kick_cnt[i];
      if (!quasi[i] || !i_pin_output_value[i]) begin
        next_kick_seen[i] = 1'b0;
        next_kick_cnt[i] = '0;
      end else if (kick_cnt[i] != '0) begin
        next_kick_cnt[i] = kick_cnt[i] - 1'b1;
      end else if (!kick_seen[i]) begin
        next_kick_seen[i] = 1'b1;
        if (!sync_b[i]) begin
          next_kick_cnt[i] = QUASI_KICK_CYCLES;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      kick_seen <= '0;
      for (int i = 0; i < N; i++) begin
        kick_cnt[i] <= '0;
      end
    end else if (i_clk_en) begin
      kick_seen <= next_kick_seen;
      for (int i = 0; i < N; i++) begin
        kick_cnt[i] <= next_kick_cnt[i];
      end
    end
  end

  // ****************************************
  // pad drive
  // ****************************************
  logic [N-1:0] next_out;
  logic [N-1:0] next_oe;
  logic [N-1:0] pp;
  logic [N-1:0] od;

  assign pp = mode_mask(mode, MODE_PUSH_PULL);
  assign od = mode_mask(mode, MODE_OPEN_DRAIN);

  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_out[i] = 1'b0;
      next_oe[i] = 1'b0;
      if (pp[i]) begin
        next_out[i] = i_pin_output_value[i];
        next_oe[i] = 1'b1;
      end else if (od[i]) begin
        next_oe[i] = !i_pin_output_value[i];
      end else if (quasi[i]) begin
        if (!i_pin_output_value[i]) begin
          next_oe[i] = 1'b1;
        end else if (kick_cnt[i] != '0) begin
          next_out[i] = 1'b1;
          next_oe[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
      o_pull_up_en <= '0;
      o_schmitt_sel <= '0;
      o_pin_mode <= '0;
      o_pin_level_input <= '0;
    end else if (i_clk_en) begin
      o_pin_out <= next_out;
      o_pin_oe <= next_oe;
      o_pull_up_en <= quasi;
      o_schmitt_sel <= i_input_buffer_type;
      o_pin_mode <= mode;
      o_pin_level_input <= sync_b;
    end
  end

  // ****************************************
  // interrupt and wake-up detection
  // ****************************************
  logic [N-1:0] edge_lvl;
  logic [N-1:0] prev_lvl;
  logic [N-1:0] hit;
  logic [N-1:0] next_status;

  assign edge_lvl = (i_debounce_enable & filt) | (~i_debounce_enable & sync_b);

  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (i_pin_irq_trigger_type[2*i +: 2])
        TRIG_LOW_LEVEL: hit[i] = !sync_b[i];
        TRIG_HIGH_LEVEL: hit[i] = sync_b[i];
        TRIG_FALLING: hit[i] = prev_lvl[i] && !edge_lvl[i];
        TRIG_RISING: hit[i] = !prev_lvl[i] && edge_lvl[i];
        default: hit[i] = 1'b0;
      endcase
    end
    hit = hit & i_pin_irq_enable & {N{armed}};
    // a new hit in the clearing cycle survives the clear
    next_status = (o_irq_status & ~i_irq_status_clear) | hit;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_lvl <= '0;
      o_irq_status <= '0;
      o_irq <= RESET_LOW;
      o_wakeup <= RESET_LOW;
    end else if (i_clk_en) begin
      prev_lvl <= edge_lvl;
      o_irq_status <= next_status;
      o_irq <= |next_status;
      o_wakeup <= i_low_power && (|hit);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n || !i_clk_en);

  sequence s_kick_start;
    $rose(o_pin_oe[0] && o_pin_out[0]) && o_pull_up_en[0];
  endsequence
  sequence s_kick_end;
    (o_pin_oe[0] && o_pin_out[0]) [*2] ##1 !(o_pin_oe[0] && o_pin_out[0]);
  endsequence

  a_input_no_drive: assert property ($past(i_clk_en) |-> (o_pin_oe & $past(mode_mask(mode, MODE_INPUT))) == '0)
    else $error("input mode pin is driven");
  a_push_pull_drive: assert property ($past(i_clk_en) |->
      ((o_pin_oe & $past(pp)) == $past(pp)) && ((o_pin_out & $past(pp)) == $past(i_pin_output_value & pp)))
    else $error("push-pull pin not driving its data");
  a_open_drain_low: assert property ($past(i_clk_en) |->
      ((o_pin_out & $past(od)) == '0) && ((o_pin_oe & $past(od)) == $past(~i_pin_output_value & od)))
    else $error("open-drain pin drive wrong");
  a_quasi_low_drive: assert property ($past(i_clk_en) |->
      (o_pin_oe & $past(quasi & ~i_pin_output_value)) == $past(quasi & ~i_pin_output_value))
    else $error("quasi pin with data 0 not driven low");
  a_quasi_kick_len: assert property (s_kick_start |-> s_kick_end)
    else $error("quasi strong-high kick not two cycles");
  a_pull_up_quasi: assert property ($past(i_clk_en) |-> o_pull_up_en == $past(quasi))
    else $error("pull-up not tied to quasi mode");
  a_boot_mode_load: assert property ($rose(boot_done) |=>
      o_pin_mode == {N{$past(i_boot_config_word_quasi, 2) ? MODE_QUASI : MODE_INPUT}})
    else $error("boot mode not loaded from strap");
  a_level_input_track: assert property ($past(i_clk_en, 3) && $past(i_clk_en, 2) && $past(i_clk_en) &&
      $past(i_reset_n, 3) && $past(i_reset_n, 2) && $past(i_reset_n) |->
      o_pin_level_input == $past(i_pin, 3))
    else $error("level input does not follow pins");
  a_status_sticky: assert property ($past(i_clk_en) |->
      (($past(o_irq_status) & ~$past(i_irq_status_clear)) & ~o_irq_status) == '0)
    else $error("status bit lost without clear");
  a_wake_needs_enable: assert property (o_wakeup |-> $past(i_low_power) && $past(|(i_pin_irq_enable & hit)))
    else $error("wake-up without enabled trigger");
  a_irq_follows_status: assert property (o_irq == (|o_irq_status))
    else $error("interrupt line disagrees with status");

endmodule

// ### hw/gpio_port_pkg.sv
// shared constants and carrier types of the general purpose pin block
package gpio_port_pkg;
  // ****************************************
  // pin organisation
  // ****************************************
  localparam int PORT_COUNT = 6;
  localparam int FULL_PORT_PINS = 16;
  localparam int LAST_PORT_PINS = 4;
  localparam int PIN_COUNT = (PORT_COUNT - 1) * FULL_PORT_PINS + LAST_PORT_PINS;

  // ****************************************
  // pin mode field codes
  // ****************************************
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] MODE_QUASI = 2'h3;

  // ****************************************
  // trigger type codes
  // ****************************************
  localparam logic [1:0] TRIG_LOW_LEVEL = 2'h0;
  localparam logic [1:0] TRIG_HIGH_LEVEL = 2'h1;
  localparam logic [1:0] TRIG_FALLING = 2'h2;
  localparam logic [1:0] TRIG_RISING = 2'h3;

  // ****************************************
  // timing and reset values
  // ****************************************
  localparam logic [1:0] QUASI_KICK_CYCLES = 2'h2;
  localparam int DEBOUNCE_COUNT_WIDTH = 4;
  localparam logic [2:0] INPUT_SETTLE_CYCLES = 3'h4;
  localparam logic RESET_LOW = 1'h0;
  localparam logic RESET_HIGH = 1'h1;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic use_tick;
    logic [DEBOUNCE_COUNT_WIDTH-1:0] cycles;
  } debounce_cfg_s;
endpackage

// ### verification/pin_board_model.sv
// board model: pad wires with a board pull-up and a test driver per pin
`timescale 1ns/1ps
module pin_board_model #(
  parameter int N = 80
) (
  input wire logic [N-1:0] i_oe,
  input wire logic [N-1:0] i_out,
  input wire logic [N-1:0] i_ext_en,
  input wire logic [N-1:0] i_ext_level,
  output logic [N-1:0] o_pin
);
  // the block's drive beats the test driver, which beats the weak pull-ups
  always_comb begin
    for (int k = 0; k < N; k++) begin
      if (i_oe[k]) begin
        o_pin[k] = i_out[k];
      end else if (i_ext_en[k]) begin
        o_pin[k] = i_ext_level[k];
      end else begin
        o_pin[k] = 1'b1;
      end
    end
  end
endmodule

// ### verification/tb_top.sv
// self-checking bench for the general purpose pin block
`timescale 1ns/1ps
module tb_top;
  import gpio_port_pkg::*;
  typedef struct {int kind; logic [159:0] mask; logic [159:0] exp;} note_s;
  logic clk = 0, rst_n = 0, wr = 0, lp = 0, saw_wake = 0, ce = 1, strap = 1, dtick = 0;
  logic [159:0] mode = '0, trig = '0, pm;
  logic [79:0] dout = '0, btype = '0, ien = '0, deb = '0, clr = '0, ext_en = '0, ext_lv = '0;
  logic [79:0] pin, oe, out, pu, sch, lvl, st, e_oe, e_pu, e_lv;
  logic irq, wake;
  logic [1:0] m;
  debounce_cfg_s dcfg = '0;
  int mismatches = 0, check_count = 0, cyc = 0, kick = 0;
  note_s q[$];
  event look;
  string names[10] = '{"mode", "oe", "out", "pull_up", "level", "status", "irq", "wake", "schmitt", "kick"};

  gpio_port_block gpio_port_block_i (.i_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce),
    .i_boot_config_word_quasi(strap), .i_mode_write(wr), .i_pin_mode_select(mode),
    .i_pin_output_value(dout), .i_input_buffer_type(btype), .i_pin_irq_enable(ien),
    .i_pin_irq_trigger_type(trig), .i_debounce_enable(deb), .i_debounce_cfg(dcfg),
    .i_debounce_tick(dtick), .i_irq_status_clear(clr), .i_low_power(lp), .i_pin(pin),
    .o_pin_out(out), .o_pin_oe(oe), .o_pull_up_en(pu), .o_schmitt_sel(sch), .o_pin_mode(pm),
    .o_pin_level_input(lvl), .o_irq_status(st), .o_irq(irq), .o_wakeup(wake));
  pin_board_model pin_board_model_i (.i_oe(oe), .i_out(out), .i_ext_en(ext_en),
    .i_ext_level(ext_lv), .o_pin(pin));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) saw_wake <= 1'b1;
    // far above the few hundred cycles the tests need
    if (cyc == 2000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  // ****************************************
  // checking
  // ****************************************
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic expect_val(int kind, logic [159:0] mask, logic [159:0] exp);
    q.push_back('{kind, mask, exp});
    ->look;
  endtask
  task automatic compare_bits(string name, logic [159:0] exp, logic [159:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [159:0] seen(int k);
    case (k)
      0: return pm;
      1: return oe;
      2: return out;
      3: return pu;
      4: return lvl;
      5: return st;
      6: return irq;
      7: return saw_wake;
      8: return sch;
      default: return kick;
    endcase
  endfunction
  // one nanosecond after the edge the registered outputs have settled
  initial forever begin
    note_s n;
    @(look);
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      compare_bits(names[n.kind], n.exp & n.mask, seen(n.kind) & n.mask);
    end
  end
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic write_mode();
    wr <= 1'b1;
    step(1);
    wr <= 1'b0;
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    void'($urandom(32'h5ecf));
    step(8);
    rst_n <= 1'b1;
    step(4);
    expect_val(0, '1, {80{MODE_QUASI}});
    expect_val(3, '1, {80{1'b1}});
    repeat (4) begin
      mode <= {$urandom, $urandom, $urandom, $urandom, $urandom};
      dout <= 80'({$urandom, $urandom, $urandom});
      btype <= 80'({$urandom, $urandom, $urandom});
      write_mode();
      step(12);
      for (int k = 0; k < 80; k++) begin
        m = mode[2*k+:2];
        e_oe[k] = (m == MODE_PUSH_PULL) || (m != MODE_INPUT && !dout[k]);
        e_pu[k] = (m == MODE_QUASI);
        e_lv[k] = e_oe[k] ? dout[k] : 1'b1;
      end
      expect_val(0, '1, mode);
      expect_val(1, '1, e_oe);
      expect_val(2, e_oe, dout);
      expect_val(3, '1, e_pu);
      expect_val(4, '1, e_lv);
      expect_val(8, '1, btype);
    end
    mode <= {80{MODE_QUASI}};
    dout <= '0;
    ext_en[0] <= 1'b1;
    write_mode();
    step(8);
    dout[0] <= 1'b1;
    repeat (8) begin
      step(1);
      if (oe[0] === 1'b1 && out[0] === 1'b1) kick++;
    end
    expect_val(9, '1, 160'h2);
    mode <= '0;
    dout <= '1;
    ext_en <= '1;
    lp <= 1'b1;
    write_mode();
    for (int t = 0; t < 8; t++) begin
      ext_lv[1] <= ~t[0];
      trig[3:2] <= t[1:0];
      ien[1] <= !t[2];
      step(6);
      clr[1] <= 1'b1;
      step(1);
      clr[1] <= 1'b0;
      saw_wake <= 1'b0;
      step(1);
      ext_lv[1] <= t[0];
      step(6);
      expect_val(5, 160'h2, {158'h0, !t[2], 1'b0});
      expect_val(6, '1, 160'(!t[2]));
      expect_val(7, '1, 160'(!t[2]));
    end
    trig[5:4] <= TRIG_RISING;
    ien[2] <= 1'b1;
    deb[2] <= 1'b1;
    dcfg <= '{1'b0, 4'h3};
    ext_lv[2] <= 1'b0;
    step(8);
    clr <= '1;
    step(1);
    clr <= '0;
    ext_lv[2] <= 1'b1;
    step(1);
    ext_lv[2] <= 1'b0;
    step(10);
    expect_val(5, 160'h4, 160'h0);
    ext_lv[2] <= 1'b1;
    step(12);
    expect_val(5, 160'h4, 160'h4);
    // debounce sampled only on the external tick
    dcfg <= '{1'b1, 4'h0};
    ext_lv[2] <= 1'b0;
    step(6);
    dtick <= 1'b1;
    step(1);
    dtick <= 1'b0;
    clr <= '1;
    ext_lv[2] <= 1'b1;
    step(1);
    clr <= '0;
    step(8);
    expect_val(5, 160'h4, 160'h0);
    dtick <= 1'b1;
    step(1);
    dtick <= 1'b0;
    step(4);
    expect_val(5, 160'h4, 160'h4);
    // second reset with the strap low, then a mode write while frozen
    step(1);
    strap <= 1'b0;
    rst_n <= 1'b0;
    step(2);
    rst_n <= 1'b1;
    step(4);
    expect_val(0, '1, '0);
    expect_val(3, '1, '0);
    ce <= 1'b0;
    mode <= {80{MODE_PUSH_PULL}};
    wr <= 1'b1;
    step(3);
    wr <= 1'b0;
    ce <= 1'b1;
    step(4);
    expect_val(0, '1, '0);
    expect_val(1, '1, '0);
    step(2);
    close_out();
  end
endmodule
